//--- rtl/wpc_pkg.sv
package wpc_pkg;
  // ==========================================
  // mode field and power-down bits
  localparam int         WAKE_MODE_LSB   = 1;
  localparam int         WAKE_MODE_W     = 3;
  localparam logic [2:0] WAKE_MODE_EDGE  = 3'h4;
  localparam int         PD_EN_BIT       = 3;
  localparam int         PD_CMD_BIT      = 0;
  // ==========================================
  // timing
  localparam longint     CLK_HZ          = 25000000;
  localparam longint     OFF_DELAY_MS    = 2000;
  localparam longint     STARTUP_NS      = 5000;
  localparam longint     FUSE_MS         = 12;
  localparam longint     CLK_NS          = 40;
  localparam longint     OFF_DELAY_CYC   = OFF_DELAY_MS * (CLK_HZ / 1000);
  localparam longint     STARTUP_CYC     = (STARTUP_NS + CLK_NS - 1) / CLK_NS;
  localparam longint     FUSE_CYC        = FUSE_MS * (CLK_HZ / 1000);
  localparam int         CNT_W           = 32;
  typedef enum logic [2:0] {WPC_OFF, WPC_START, WPC_ON, WPC_HOLD, WPC_THERM} wpc_state_t;
endpackage

//--- rtl/wpc_timer.sv
`timescale 1ns/100ps
// down counter: load on start, done pulses when expiring
module wpc_timer (
  // clock
  input  wire logic                    clk,
  input  wire logic                    srst,
  input  wire logic                    ce,
  // control
  input  wire logic                    start,
  input  wire logic                    stop,
  input  wire logic [wpc_pkg::CNT_W-1:0] load,
  // status
  output logic                         busy,
  output logic                         done
);
  typedef struct packed {
    logic [wpc_pkg::CNT_W-1:0] cnt;
    logic                      busy;
    logic                      done;
  } wpc_tmr_t;
  wpc_tmr_t st_reg, st_next;

  always_comb begin
    st_next      = st_reg;
    st_next.done = 1'b0;
    if (stop) begin
      st_next.busy = 1'b0;
    end else if (start) begin
      st_next.cnt  = load;
      st_next.busy = 1'b1;
    end else if (st_reg.busy) begin
      if (st_reg.cnt <= 32'h1) begin
        st_next.busy = 1'b0;
        st_next.done = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt - 32'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign busy = st_reg.busy;
  assign done = st_reg.done;
endmodule

//--- rtl/wpc_ctrl.sv
`timescale 1ns/100ps
// Function
// [R1] default mode: wake above on-threshold powers the device on
// [R2] default mode: power off two seconds after shutdown output released
// [R3] start-up takes five microseconds before monitoring becomes active
// [R4] mode field value 100 (bits 3:1) selects rising-edge wake
// [R5] edge mode: wake input falling low keeps the device powered
// [R6] edge mode: only software power-down or battery loss powers down; over-temperature also powers down (R10)
// [R7] software power-down enable bit, 0 enables, 1 disables
// [R8] power-down command bit 1 with enable powers the device down; the code acts on it only in edge mode, in the on state
// [R9] fuse programming finishes within 12 ms per register
// [R10] over-temperature shuts down, resumes automatically when clear
// [R11] power-down command while disabled has no effect
module wpc_ctrl #(
  parameter longint OFF_DELAY_CYC = wpc_pkg::OFF_DELAY_CYC,
  parameter longint FUSE_CYC      = wpc_pkg::FUSE_CYC
) (
  // clock
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       ce,
  // monitor comparators
  input  wire logic       wake_above_on,
  input  wire logic       wake_below_off,
  input  wire logic       battery_present,
  input  wire logic       over_temp,
  input  wire logic       shutdown_out_n,
  // configuration
  input  wire logic [3:0] wake_off_threshold,
  input  wire logic [7:0] sw_ctrl_cfg,
  input  wire logic [7:0] pd_cmd,
  input  wire logic       pd_cmd_wr,
  input  wire logic       fuse_start,
  // status
  output logic            regulator_en,
  output logic            monitor_active,
  output logic            edge_mode,
  output logic            fuse_busy,
  output logic            fuse_done
);
  typedef struct packed {
    wpc_pkg::wpc_state_t state;
    logic                shutdown_out_seen;
    logic                reg_en;
    logic                mon_act;
    logic [wpc_pkg::CNT_W-1:0] pwr_cyc;
    logic [wpc_pkg::CNT_W-1:0] fuse_cyc;
  } wpc_ctrl_st_t;
  wpc_ctrl_st_t st_reg, st_next;

  logic start_tmr, off_tmr_start, off_tmr_stop, off_busy, off_done, st_done, st_busy;
  logic pd_req;

  function automatic logic is_edge_mode(input logic [3:0] thr);
    return thr[wpc_pkg::WAKE_MODE_LSB +: wpc_pkg::WAKE_MODE_W] == wpc_pkg::WAKE_MODE_EDGE; // R4
  endfunction

  // ==========================================
  // software power-down request
  assign pd_req = pd_cmd_wr && pd_cmd[wpc_pkg::PD_CMD_BIT]
                  && !sw_ctrl_cfg[wpc_pkg::PD_EN_BIT]; // R7 R8 R11

  // ==========================================
  // state machine
  always_comb begin
    st_next       = st_reg;
    start_tmr     = 1'b0;
    off_tmr_start = 1'b0;
    off_tmr_stop  = 1'b0;
    unique case (st_reg.state)
      wpc_pkg::WPC_OFF: begin
        if (battery_present && wake_above_on && !over_temp) begin // R1
          st_next.state = wpc_pkg::WPC_START;
          start_tmr     = 1'b1;
        end
      end
      wpc_pkg::WPC_START: begin
        if (st_done) begin
          st_next.state = wpc_pkg::WPC_ON; // R3
        end
      end
      wpc_pkg::WPC_ON: begin
        if (is_edge_mode(wake_off_threshold)) begin
          if (pd_req) begin
            st_next.state = wpc_pkg::WPC_OFF; // R6 R8
          end
        end else if (wake_below_off) begin
          st_next.state     = wpc_pkg::WPC_HOLD; // R5 only default mode enters hold from here
          st_next.shutdown_out_seen = 1'b0;
        end
      end
      wpc_pkg::WPC_HOLD: begin
        // delay starts only once the shutdown output is released high
        if (!st_reg.shutdown_out_seen && shutdown_out_n) begin
          st_next.shutdown_out_seen = 1'b1;
          off_tmr_start     = 1'b1;
        end
        if (wake_above_on) begin
          st_next.state = wpc_pkg::WPC_ON;
          off_tmr_stop  = 1'b1;
        end else if (off_done) begin
          st_next.state = wpc_pkg::WPC_OFF; // R2
        end
      end
      wpc_pkg::WPC_THERM: begin
        if (!over_temp) begin
          st_next.state = wpc_pkg::WPC_START; // R10
          start_tmr     = 1'b1;
        end
      end
      default: st_next.state = wpc_pkg::WPC_OFF;
    endcase
    // battery loss overrides every state, over-temperature every state but off
    if (!battery_present) begin
      st_next.state = wpc_pkg::WPC_OFF; // R6
      off_tmr_stop  = 1'b1;
    end else if (over_temp && st_reg.state != wpc_pkg::WPC_OFF) begin
      st_next.state = wpc_pkg::WPC_THERM; // R10
      off_tmr_stop  = 1'b1;
    end
    st_next.reg_en  = st_next.state != wpc_pkg::WPC_OFF && st_next.state != wpc_pkg::WPC_THERM;
    st_next.mon_act = st_next.state == wpc_pkg::WPC_ON || st_next.state == wpc_pkg::WPC_HOLD;
    // cycle counters for the checks: pwr_cyc saturates at STARTUP_CYC while powered, fuse_cyc clears when not busy
    if (!st_reg.reg_en) begin
      st_next.pwr_cyc = '0;
    end else if (st_reg.pwr_cyc < wpc_pkg::CNT_W'(wpc_pkg::STARTUP_CYC)) begin
      st_next.pwr_cyc = st_reg.pwr_cyc + 32'h1;
    end
    st_next.fuse_cyc = fuse_busy ? st_reg.fuse_cyc + 32'h1 : '0;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '{state: wpc_pkg::WPC_OFF, default: '0};
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // ==========================================
  // timers: one shared start-up/fuse timer would clash, so three
  wpc_timer u_start (
    .clk  (clk),
    .srst (srst),
    .ce   (ce),
    .start(start_tmr),
    .stop (1'b0),
    .load (wpc_pkg::CNT_W'(wpc_pkg::STARTUP_CYC)),
    .busy (st_busy),
    .done (st_done)
  );
  wpc_timer u_off (
    .clk  (clk),
    .srst (srst),
    .ce   (ce),
    .start(off_tmr_start),
    .stop (off_tmr_stop),
    .load (wpc_pkg::CNT_W'(OFF_DELAY_CYC)),
    .busy (off_busy),
    .done (off_done)
  );
  // fuse busy window; new starts while busy are ignored
  wpc_timer u_fuse (
    .clk  (clk),
    .srst (srst),
    .ce   (ce),
    .start(fuse_start && !fuse_busy),
    .stop (1'b0),
    .load (wpc_pkg::CNT_W'(FUSE_CYC)),
    .busy (fuse_busy),
    .done (fuse_done)
  ); // R9

  assign regulator_en   = st_reg.reg_en;
  assign monitor_active = st_reg.mon_act;
  assign edge_mode      = is_edge_mode(wake_off_threshold);

  // ==========================================
  // checks
  sequence s_sw_pd;
    ce && pd_req && st_reg.state == wpc_pkg::WPC_ON && is_edge_mode(wake_off_threshold) && battery_present
      && !over_temp;
  endsequence
  // off delay expiring in hold with the wake input still low
  sequence s_hold_expire;
    ce && st_reg.state == wpc_pkg::WPC_HOLD && off_done && !wake_above_on && battery_present;
  endsequence
  a_wake_power_on: assert property (@(posedge clk) disable iff (srst) // R1
    ce && st_reg.state == wpc_pkg::WPC_OFF && battery_present && wake_above_on && !over_temp |=> regulator_en)
    else $error("wake did not power on");
  a_startup_time: assert property (@(posedge clk) disable iff (srst) // R3
    $rose(monitor_active) |-> st_reg.pwr_cyc >= wpc_pkg::CNT_W'(wpc_pkg::STARTUP_CYC))
    else $error("monitor active during start-up");
  a_edge_stays_on: assert property (@(posedge clk) disable iff (srst) // R5
    ce && st_reg.state == wpc_pkg::WPC_ON && edge_mode && !pd_req && battery_present && !over_temp |=> regulator_en)
    else $error("edge mode dropped power");
  a_sw_power_down: assert property (@(posedge clk) disable iff (srst) // R8
    s_sw_pd |=> !regulator_en)
    else $error("software power-down ignored");
  a_pd_disabled: assert property (@(posedge clk) disable iff (srst) // R11
    ce && st_reg.state == wpc_pkg::WPC_ON && edge_mode && pd_cmd_wr && sw_ctrl_cfg[wpc_pkg::PD_EN_BIT]
      && battery_present && !over_temp |=> regulator_en)
    else $error("power-down taken while disabled");
  a_battery_loss: assert property (@(posedge clk) disable iff (srst) // R6
    ce && !battery_present |=> !regulator_en)
    else $error("battery loss did not power down");
  a_therm_off: assert property (@(posedge clk) disable iff (srst) // R10
    ce && over_temp && battery_present && regulator_en |=> !regulator_en)
    else $error("over-temperature did not cut power");
  a_default_hold: assert property (@(posedge clk) disable iff (srst) // R2
    $rose(off_busy) |-> regulator_en)
    else $error("off delay started while unpowered");
  a_fuse_window: assert property (@(posedge clk) disable iff (srst) // R9
    $rose(fuse_busy) |-> ##1 fuse_busy)
    else $error("fuse window too short");
  a_hold_expire: assert property (@(posedge clk) disable iff (srst) // R2
    s_hold_expire |=> !regulator_en)
    else $error("off delay expired without power-off");
  a_therm_resume: assert property (@(posedge clk) disable iff (srst) // R10
    ce && st_reg.state == wpc_pkg::WPC_THERM && !over_temp && battery_present |=> regulator_en)
    else $error("no resume after over-temperature");
  a_fuse_length: assert property (@(posedge clk) disable iff (srst) // R9
    $fell(fuse_busy) |-> st_reg.fuse_cyc == wpc_pkg::CNT_W'(FUSE_CYC))
    else $error("fuse window length wrong");
endmodule

//--- sim/wpc_host.sv
`timescale 1ns/100ps
// ==========================================
// host side: power-down config and writes, fuse programming starts
module wpc_host #(
  parameter int FUSE_CYC = 10
) (
  // clock
  input  wire logic       clk,
  // control link
  output logic      [7:0] sw_ctrl_cfg,
  output logic      [7:0] pd_cmd,
  output logic            pd_cmd_wr,
  output logic            fuse_start
);
  initial begin
    sw_ctrl_cfg = 8'h08;
    pd_cmd      = 8'h00;
    pd_cmd_wr   = 1'b0;
    fuse_start  = 1'b0;
  end
  // enable bit is settled one cycle before the command strobe
  task automatic pd_write(input logic dis, input logic val);
    @(posedge clk);
    #1;
    sw_ctrl_cfg[3] = dis;
    @(posedge clk);
    #1;
    pd_cmd    = {7'($urandom), val};
    pd_cmd_wr = 1'b1;
    @(posedge clk);
    #1;
    pd_cmd_wr = 1'b0;
  endtask
  task automatic fuse_once;
    @(posedge clk);
    #1;
    fuse_start = 1'b1;
    @(posedge clk);
    #1;
    fuse_start = 1'b0;
    // no next start until the programming window has surely ended
    repeat (FUSE_CYC + 2) @(posedge clk);
  endtask
endmodule

//--- sim/wpc_ctrl_tb.sv
`timescale 1ns/100ps
module wpc_ctrl_tb;
  localparam longint OFF  = 20;
  localparam longint FUSE = 10;
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic       ce = 1'b1;
  logic       wake_above_on, wake_below_off, battery_present, over_temp, shutdown_out_n;
  logic [3:0] wake_off_threshold;
  logic [7:0] sw_ctrl_cfg, pd_cmd;
  logic       pd_cmd_wr, fuse_start, regulator_en, monitor_active, edge_mode, fuse_busy, fuse_done;
  int         miscompares = 0;
  int         checks_done = 0;
  int         n, busy_cnt, done_cnt;
  logic       exp_on;
  initial begin
    forever #20 clk = ~clk;
  end
  wpc_ctrl #(.OFF_DELAY_CYC(OFF), .FUSE_CYC(FUSE)) u_wpc_ctrl (.clk(clk), .srst(srst), .ce(ce),
    .wake_above_on(wake_above_on), .wake_below_off(wake_below_off), .battery_present(battery_present),
    .over_temp(over_temp), .shutdown_out_n(shutdown_out_n), .wake_off_threshold(wake_off_threshold),
    .sw_ctrl_cfg(sw_ctrl_cfg), .pd_cmd(pd_cmd), .pd_cmd_wr(pd_cmd_wr), .fuse_start(fuse_start),
    .regulator_en(regulator_en), .monitor_active(monitor_active), .edge_mode(edge_mode),
    .fuse_busy(fuse_busy), .fuse_done(fuse_done));
  wpc_host #(.FUSE_CYC(FUSE)) u_wpc_host (.clk(clk), .sw_ctrl_cfg(sw_ctrl_cfg), .pd_cmd(pd_cmd),
    .pd_cmd_wr(pd_cmd_wr), .fuse_start(fuse_start));
  always @(negedge clk) begin
    if (fuse_busy === 1'b1) busy_cnt++;
    if (fuse_done === 1'b1) done_cnt++;
  end
  // ==========================================
  // helpers
  task automatic chk(input string what, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %0b got %0b", what, e, g);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // bounded wait on regulator_en (sel 0) or monitor_active (sel 1)
  task automatic wait_out(input bit sel, input logic v, input int lim, output int c);
    c = 0;
    while ((sel ? monitor_active : regulator_en) !== v && c < lim) begin
      step(1);
      c++;
    end
  endtask
  task automatic end_sim;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #(40 * 5000);
    miscompares++;
    end_sim;
  end
  // ==========================================
  // tests
  initial begin
    void'($urandom(32'h61fe));
    {wake_above_on, over_temp, shutdown_out_n} = 3'h0;
    {wake_below_off, battery_present} = 2'h3;
    wake_off_threshold = 4'h0;
    busy_cnt = 0;
    done_cnt = 0;
    step(6);
    srst = 1'b0;
    exp_on = 1'b0;
    chk("reg_rst", exp_on, regulator_en);
    chk("edge_def", 1'b0, edge_mode);
    {wake_above_on, wake_below_off} = 2'h2;
    exp_on = 1'b1;
    wait_out(0, 1'b1, 4, n);
    chk("reg_on", exp_on, regulator_en);
    wait_out(1, 1'b1, 140, n);
    chk("start_time", 1'b1, 1'(n >= 124 && n <= 130));
    {wake_above_on, wake_below_off} = 2'h1;
    step(3);
    chk("hold", exp_on, regulator_en);
    shutdown_out_n = 1'b1;
    wait_out(0, 1'b0, int'(OFF) + 10, n);
    exp_on = 1'b0;
    chk("off", exp_on, regulator_en);
    chk("off_delay", 1'b1, 1'(n >= OFF - 2 && n <= OFF + 3));
    $display("test default mode done");
    wake_off_threshold = {3'h4, 1'($urandom)};
    step(1);
    chk("edge", 1'b1, edge_mode);
    {wake_above_on, wake_below_off} = 2'h2;
    wait_out(1, 1'b1, 140, n);
    {wake_above_on, wake_below_off} = 2'h1;
    step(int'(OFF) + 5);
    chk("edge_hold", 1'b1, regulator_en);
    u_wpc_host.pd_write(1'b1, 1'b1);
    step(3);
    chk("pd_dis", 1'b1, regulator_en);
    u_wpc_host.pd_write(1'b0, 1'b0);
    step(3);
    chk("pd_zero", 1'b1, regulator_en);
    u_wpc_host.pd_write(1'b0, 1'b1);
    step(2);
    chk("pd_off", 1'b0, regulator_en);
    wake_above_on = 1'b1;
    wait_out(1, 1'b1, 140, n);
    wake_above_on = 1'b0;
    battery_present = 1'b0;
    step(3);
    chk("batt_loss", 1'b0, regulator_en);
    $display("test edge mode done");
    {battery_present, wake_above_on} = 2'h3;
    wake_off_threshold = 4'h0;
    wait_out(0, 1'b1, 10, n);
    over_temp = 1'b1;
    step(3);
    chk("therm_off", 1'b0, regulator_en);
    over_temp = 1'b0;
    wait_out(0, 1'b1, 10, n);
    chk("therm_resume", 1'b1, regulator_en);
    ce = 1'b0;
    over_temp = 1'b1;
    step(3);
    chk("ce_freeze", 1'b1, regulator_en);
    {ce, over_temp} = 2'h2;
    $display("test thermal done");
    u_wpc_host.fuse_once;
    chk("fuse_busy", 1'b1, 1'(busy_cnt >= FUSE - 1 && busy_cnt <= FUSE));
    chk("fuse_done", 1'b1, 1'(done_cnt == 1));
    $display("test fuse done");
    end_sim;
  end
endmodule
